// ==== logic/sbrc_top.sv ====
// Operation
// RULE1: 18-bit threshold, control word resets 0003FFFE
// RULE2: Flag high when fill count exceeds threshold
// RULE3: Zero threshold, flag fall is empty event
// RULE4: Software picks rising or falling flag event
// RULE5: Flush empties, holds 10 us, self-clears
// RULE6: Intake block stops writes, keeps contents
// RULE7: Width code selects 16/18/20/24 data bits
// RULE8: Flag overflow on full write, underflow empty
// RULE9: Error flags stick until written zero
// RULE10: Read-only fill count register
// RULE11: Host sync flushes when flush-on-sync enabled
// RULE12: Software flushes to start, blocks to stop
// RULE13: Source codes in bits 3:0 and 7:4
// RULE14: Source codes: A, B, external, direct, off
// RULE15: Disabled group delivers no samples
// RULE16: Scan sync clocks all from channel 00
// RULE17: Channels split into two equal halves
// RULE18: Divisor codes bits 7:0, 15:8, reset 0505
// RULE19: Factor is code, or half when zero
// RULE20: External generator clock 25.6 to 51.2 MHz
// RULE21: Divisor code also picks clocking mode
// RULE22: Rate is generator over 512 times factor
// RULE23: Buffer holds 256K sample values
// RULE24: Sample on full is discarded
`timescale 1ns/100ps
`include "sbrc_defs.svh"

module sbrc_top #(
	parameter int DEPTH = `SBRC_DEPTH,
	parameter int NCH = `SBRC_NCH,
	parameter int CW = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Host register port
	input wire sbrc_pkg::sbrc_req_t reg_req,
	output logic [31:0] reg_rdata,
	// Loose control bits from the board control word
	input wire logic host_sync_pulse,
	input wire logic flush_on_sync,
	input wire logic scan_sync_sel,
	input wire logic edge_sel_fall,
	// Clock sources
	input wire logic gen_a_tick,
	input wire logic gen_b_tick,
	input wire logic ext_clk_pin,
	// Converter samples and buffer read side
	input wire sbrc_pkg::sbrc_sample_t smp,
	input wire logic buf_rd,
	// Buffer write side
	output logic buf_wr_en,
	output logic [31:0] buf_wr_word,
	output logic buf_flush,
	// Threshold flag and events
	output logic thr_flag,
	output logic thr_evt,
	output logic empty_evt,
	// Converter clocks
	output logic [1:0] conv_tick,
	output logic [1:0] conv_mode0,
	output logic [1:0] conv_mode1
);

	localparam int FLUSH_CYC = `SBRC_FLUSH_CYC;
	localparam logic [4:0] HALF = 5'(NCH / 2);

	// Control registers
	logic [7:0] src_sel;
	logic [15:0] div_codes;
	logic [17:0] thr;
	logic inblk;
	logic [1:0] wid;
	logic ovf;
	logic unf;
	logic [7:0] next_src_sel;
	logic [15:0] next_div_codes;
	logic [17:0] next_thr;
	logic next_inblk;
	logic [1:0] next_wid;
	logic next_ovf;
	logic next_unf;
	logic [31:0] next_rdata;

	// Flush sequencer
	sbrc_pkg::sbrc_fl_t fl_state;
	sbrc_pkg::sbrc_fl_t next_fl_state;
	logic [8:0] fl_cnt;
	logic [8:0] next_fl_cnt;
	logic fl_req;

	// Datapath
	logic next_wr_en;
	logic [31:0] next_wr_word;
	logic next_thr_flag;
	logic next_thr_evt;
	logic next_empty_evt;
	logic [1:0] next_conv_tick;
	logic arrive;
	logic accept;
	logic grp;
	logic [23:0] mask;

	// External clock pin synchroniser and edge detect
	logic ext_s1;
	logic ext_s2;
	logic ext_s3;
	logic ext_tick;

	// Submodule outputs
	logic [CW-1:0] fill_cnt;
	logic full;
	logic empty;
	logic [1:0] grp_off;
	logic [1:0] grp_tick;
	logic [1:0] mode0;
	logic [1:0] mode1;

	wire ctl_wr = reg_req.wr && (reg_req.addr == `SBRC_OFS_CTL);
	wire busy = (fl_state == sbrc_pkg::SBRC_FL_HOLD);

	assign ext_tick = ext_s2 && !ext_s3;

	// Fill level of the buffer
	sbrc_fill_ctr #(
		.DEPTH(DEPTH),
		.CW(CW)
	) u_fill (
		.mclk(mclk),
		.rst_b(rst_b),
		.push(accept),
		.pop(buf_rd),
		.clear(busy),
		.count(fill_cnt),
		.full(full),
		.empty(empty)
	);

	// One divider per channel group
	for (genvar g = 0; g < 2; g++) begin : g_grp
		logic [1:0] gmode;
		sbrc_rate_gen #(
			.PRESCALE(`SBRC_PRESCALE)
		) u_rate (
			.mclk(mclk),
			.rst_b(rst_b),
			.gen_a_tick(gen_a_tick),
			.gen_b_tick(gen_b_tick),
			.ext_tick(ext_tick),
			.src(src_sel[4*g +: 4]), // see RULE13
			.div(div_codes[8*g +: 8]), // see RULE18
			.off(grp_off[g]),
			.tick(grp_tick[g]),
			.mode(gmode)
		);
	end
	assign mode0 = g_grp[0].gmode;
	assign mode1 = g_grp[1].gmode;

	// Flush starts on a control write with the flush bit set, or on host sync when enabled
	assign fl_req = (ctl_wr && reg_req.wdata[`SBRC_CTL_FLUSH]) // see RULE5
		|| (host_sync_pulse && flush_on_sync); // see RULE11

	// Flush sequencer: hold the buffer empty for the pipeline drain time
	always_comb begin
		next_fl_state = fl_state;
		next_fl_cnt = fl_cnt;
		case (fl_state)
			sbrc_pkg::SBRC_FL_IDLE: begin
				if (fl_req) begin
					next_fl_state = sbrc_pkg::SBRC_FL_HOLD;
					next_fl_cnt = '0;
				end
			end
			sbrc_pkg::SBRC_FL_HOLD: begin
				// A new request while holding restarts the drain time
				if (fl_req) begin
					next_fl_cnt = '0;
				end else if (fl_cnt == 9'(FLUSH_CYC - 1)) begin
					next_fl_state = sbrc_pkg::SBRC_FL_IDLE; // see RULE5
				end else begin
					next_fl_cnt = fl_cnt + 9'd1;
				end
			end
			default: next_fl_state = sbrc_pkg::SBRC_FL_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fl_state <= sbrc_pkg::SBRC_FL_IDLE;
			fl_cnt <= '0;
		end else begin
			fl_state <= next_fl_state;
			fl_cnt <= next_fl_cnt;
		end
	end

	// Register writes, sticky error flags and read data
	always_comb begin
		next_src_sel = src_sel;
		next_div_codes = div_codes;
		next_thr = thr;
		next_inblk = inblk;
		next_wid = wid;
		next_ovf = ovf;
		next_unf = unf;
		next_rdata = reg_rdata;
		if (reg_req.wr && reg_req.addr == `SBRC_OFS_SRC) begin
			next_src_sel = reg_req.wdata[7:0];
		end
		if (reg_req.wr && reg_req.addr == `SBRC_OFS_DIV) begin
			next_div_codes = reg_req.wdata[15:0];
		end
		if (ctl_wr) begin
			next_thr = reg_req.wdata[`SBRC_CTL_THR_MSB:0]; // see RULE1
			next_inblk = reg_req.wdata[`SBRC_CTL_INBLK];
			next_wid = reg_req.wdata[`SBRC_CTL_WID_MSB:`SBRC_CTL_WID_LSB];
			// Writing zero clears; writing one leaves the flag alone
			next_ovf = ovf && reg_req.wdata[`SBRC_CTL_OVF]; // see RULE9
			next_unf = unf && reg_req.wdata[`SBRC_CTL_UNF];
		end
		// Set wins over a clear in the same cycle
		if (arrive && full) begin
			next_ovf = 1'b1; // see RULE8
		end
		if (buf_rd && empty) begin
			next_unf = 1'b1; // see RULE8
		end
		if (reg_req.rd) begin
			case (reg_req.addr)
				`SBRC_OFS_SRC: next_rdata = {24'h00_0000, src_sel};
				`SBRC_OFS_DIV: next_rdata = {16'h0000, div_codes};
				`SBRC_OFS_CTL: next_rdata = {6'h00, unf, ovf, 2'b00, wid, busy, inblk, thr};
				`SBRC_OFS_CNT: next_rdata = 32'(fill_cnt); // see RULE10
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			src_sel <= 8'(`SBRC_RST_SRC);
			div_codes <= 16'(`SBRC_RST_DIV); // see RULE18
			thr <= 18'(`SBRC_RST_CTL);
			inblk <= 1'b0;
			wid <= 2'b00;
			ovf <= 1'b0;
			unf <= 1'b0;
			reg_rdata <= 32'h0000_0000;
		end else begin
			src_sel <= next_src_sel;
			div_codes <= next_div_codes;
			thr <= next_thr;
			inblk <= next_inblk;
			wid <= next_wid;
			ovf <= next_ovf;
			unf <= next_unf;
			reg_rdata <= next_rdata;
		end
	end

	// Upper half of the channels forms group 1
	assign grp = (smp.chan >= HALF); // see RULE17
	// Blocked, flushing or disabled-group samples never reach the buffer
	assign arrive = smp.valid && !grp_off[grp] && !inblk && !busy; // see RULE6 RULE15
	// Full buffer drops the sample; only the overflow flag records it
	assign accept = arrive && !full; // see RULE24

	// Right-justified field width; pad bits above are zero
	always_comb begin
		case (wid)
			2'd0: mask = 24'h00_FFFF; // see RULE7
			2'd1: mask = 24'h03_FFFF;
			2'd2: mask = 24'h0F_FFFF;
			default: mask = 24'hFF_FFFF;
		endcase
	end

	// Buffer write word, flag, events and converter clocks
	always_comb begin
		next_wr_en = accept;
		next_wr_word = {3'b000, smp.chan, smp.data & mask};
		// Compared at full width: a small buffer must not truncate the limit
		next_thr_flag = (32'(fill_cnt) > 32'(thr)); // see RULE2
		// Event edge chosen by software
		next_thr_evt = edge_sel_fall ? (thr_flag && !next_thr_flag)
			: (!thr_flag && next_thr_flag); // see RULE4
		next_empty_evt = (thr == 18'h0_0000) && thr_flag && !next_thr_flag; // see RULE3
		// Scan sync drives every converter from the group 0 clock
		next_conv_tick = scan_sync_sel ? {2{grp_tick[0]}} : grp_tick; // see RULE16
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			buf_wr_en <= 1'b0;
			buf_wr_word <= 32'h0000_0000;
			buf_flush <= 1'b0;
			thr_flag <= 1'b0;
			thr_evt <= 1'b0;
			empty_evt <= 1'b0;
			conv_tick <= 2'b00;
			conv_mode0 <= 2'b00;
			conv_mode1 <= 2'b00;
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			buf_wr_en <= next_wr_en;
			buf_wr_word <= next_wr_word;
			buf_flush <= busy;
			thr_flag <= next_thr_flag;
			thr_evt <= next_thr_evt;
			empty_evt <= next_empty_evt;
			conv_tick <= next_conv_tick;
			conv_mode0 <= mode0;
			conv_mode1 <= scan_sync_sel ? mode0 : mode1;
			ext_s1 <= ext_clk_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_flag_exceeds: assert property ((32'(fill_cnt) > 32'(thr)) |=> thr_flag) // see RULE2
		else $error("threshold flag low while count exceeds limit");
	a_flush_empties: assert property ($rose(busy) |=> fill_cnt == '0 && buf_flush) // see RULE5
		else $error("flush did not empty the buffer");
	a_flush_bound: assert property (busy |-> fl_cnt < 9'(FLUSH_CYC)) // see RULE5
		else $error("flush held too long");
	a_block_nowrite: assert property (inblk |=> !buf_wr_en) // see RULE6
		else $error("write while intake blocked");
	a_ovf_set: assert property (arrive && full |=> ovf && !buf_wr_en) // see RULE8
		else $error("overflow not flagged");
	a_unf_set: assert property (buf_rd && empty |=> unf) // see RULE8
		else $error("underflow not flagged");
	a_ovf_sticky: assert property (ovf && !(ctl_wr && !reg_req.wdata[`SBRC_CTL_OVF]) |=> ovf) // see RULE9
		else $error("overflow flag dropped without a clear");
	a_empty_event: assert property ($fell(thr_flag) && $past(thr) == 18'h0_0000 && thr == 18'h0_0000 |-> empty_evt) // see RULE3
		else $error("empty event missing");
	a_scan_follow: assert property ($past(scan_sync_sel) |-> conv_tick[1] == conv_tick[0]) // see RULE16
		else $error("group 1 not following channel 00 clock");
	a_sync_flush: assert property (host_sync_pulse && flush_on_sync |=> busy) // see RULE11
		else $error("host sync did not flush");

endmodule

// ==== pkg/sbrc_defs.svh ====
`ifndef SBRC_DEFS_SVH
`define SBRC_DEFS_SVH

// Register offsets on the host register port
`define SBRC_OFS_SRC 8'h0C
`define SBRC_OFS_DIV 8'h10
`define SBRC_OFS_CTL 8'h20
`define SBRC_OFS_CNT 8'h24

// Reset values
`define SBRC_RST_SRC 32'h0000_0000
`define SBRC_RST_DIV 32'h0000_0505
`define SBRC_RST_CTL 32'h0003_FFFE

// Buffer control word field positions
`define SBRC_CTL_THR_MSB 17
`define SBRC_CTL_INBLK 18
`define SBRC_CTL_FLUSH 19
`define SBRC_CTL_WID_LSB 20
`define SBRC_CTL_WID_MSB 21
`define SBRC_CTL_OVF 24
`define SBRC_CTL_UNF 25

// Source select and divisor field positions
`define SBRC_SRC0_LSB 0
`define SBRC_SRC1_LSB 4
`define SBRC_DIV0_LSB 0
`define SBRC_DIV1_LSB 8

// Buffer capacity in sample values, and channel count
`define SBRC_DEPTH 262144
`define SBRC_NCH 12

// Generator ticks per sample at unity divide factor
`define SBRC_PRESCALE 512

// Clock period and flush hold time, both in ns
`define SBRC_CLK_NS 25
`define SBRC_FLUSH_NS 10000
`define SBRC_FLUSH_CYC (`SBRC_FLUSH_NS / `SBRC_CLK_NS)

`endif

// ==== pkg/sbrc_pkg.sv ====
package sbrc_pkg;

	// Host register request, one cycle per access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} sbrc_req_t;

	// One tagged sample from the converter channels
	typedef struct packed {
		logic valid;
		logic [4:0] chan;
		logic [23:0] data;
	} sbrc_sample_t;

	// Rate source codes of a channel group
	typedef enum logic [3:0] {
		SBRC_SRC_GEN_A = 4'h0,
		SBRC_SRC_GEN_B = 4'h1,
		SBRC_SRC_EXT_GEN = 4'h4,
		SBRC_SRC_EXT_DIRECT = 4'h5,
		SBRC_SRC_OFF_A = 4'h6,
		SBRC_SRC_OFF_B = 4'h7
	} sbrc_src_t;

	// Converter clocking modes picked by the divisor code
	typedef enum logic [1:0] {
		SBRC_MODE_LOW,
		SBRC_MODE_MID,
		SBRC_MODE_HIGH
	} sbrc_mode_t;

	// Flush sequencer states
	typedef enum logic {
		SBRC_FL_IDLE,
		SBRC_FL_HOLD
	} sbrc_fl_t;

endpackage

// ==== logic/sbrc_fill_ctr.sv ====
`timescale 1ns/100ps

// Occupancy counter of the acquisition buffer
module sbrc_fill_ctr #(
	parameter int DEPTH = 262144,
	parameter int CW = 19
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Buffer events
	input wire logic push,
	input wire logic pop,
	input wire logic clear,
	// Level
	output logic [CW-1:0] count,
	output logic full,
	output logic empty
);

	logic [CW-1:0] next_count;

	assign full = (count == CW'(DEPTH));
	assign empty = (count == '0);

	// Clear dominates; a push on full is dropped by the caller, never counted here
	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (push && !full && !(pop && !empty)) begin
			next_count = count + CW'(1);
		end else if (pop && !empty && !(push && !full)) begin
			next_count = count - CW'(1);
		end
	end

	// Count register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_full_hold: assert property (full && !pop && !clear |=> count == $past(count)) // see RULE24
		else $error("fill count moved while full");
	a_count_cap: assert property (count <= CW'(DEPTH)) // see RULE23
		else $error("fill count above capacity");

endmodule

// ==== logic/sbrc_rate_gen.sv ====
`timescale 1ns/100ps

// Sample clock enable for one channel group
module sbrc_rate_gen #(
	parameter int PRESCALE = 512
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Clock sources as one-cycle enables
	input wire logic gen_a_tick,
	input wire logic gen_b_tick,
	input wire logic ext_tick,
	// Group settings
	input wire logic [3:0] src,
	input wire logic [7:0] div,
	// Group clock
	output logic off,
	output logic tick,
	output logic [1:0] mode
);

	logic [16:0] cnt;
	logic [16:0] next_cnt;
	logic next_tick;
	logic [1:0] next_mode;
	logic src_tick;
	logic direct;
	logic [16:0] lim;

	// Source decode; reserved codes deliver no clock at all
	always_comb begin
		src_tick = 1'b0;
		direct = 1'b0;
		off = 1'b0;
		case (sbrc_pkg::sbrc_src_t'(src))
			sbrc_pkg::SBRC_SRC_GEN_A: src_tick = gen_a_tick; // see RULE14
			sbrc_pkg::SBRC_SRC_GEN_B: src_tick = gen_b_tick;
			sbrc_pkg::SBRC_SRC_EXT_GEN: src_tick = ext_tick;
			sbrc_pkg::SBRC_SRC_EXT_DIRECT: direct = 1'b1;
			sbrc_pkg::SBRC_SRC_OFF_A, sbrc_pkg::SBRC_SRC_OFF_B: off = 1'b1; // see RULE15
			default: src_tick = 1'b0;
		endcase
	end

	// Code zero halves the factor: half the prescale per sample
	assign lim = (div == 8'h00) ? 17'(PRESCALE / 2 - 1) : 17'(int'(div) * PRESCALE - 1); // see RULE19 RULE22

	// Divider and clocking mode
	always_comb begin
		next_cnt = cnt;
		next_tick = 1'b0;
		if (direct) begin
			next_cnt = '0;
			next_tick = ext_tick;
		end else if (src_tick) begin
			if (cnt >= lim) begin
				next_cnt = '0;
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + 17'd1;
			end
		end
		// Divisor code also steers the converter clocking mode
		if (div == 8'h00) begin
			next_mode = sbrc_pkg::SBRC_MODE_HIGH; // see RULE21
		end else if (div == 8'h01) begin
			next_mode = sbrc_pkg::SBRC_MODE_MID;
		end else begin
			next_mode = sbrc_pkg::SBRC_MODE_LOW;
		end
	end

	// Divider state and registered outputs
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
			tick <= 1'b0;
			mode <= 2'd0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
			mode <= next_mode;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_mode_code: assert property (div == 8'h00 |=> mode == 2'd2) // see RULE21
		else $error("divisor zero did not give high mode");
	a_off_silent: assert property (off |=> !tick) // see RULE15
		else $error("disabled group produced a tick");

endmodule

// ==== testbench/sbrc_src_model.sv ====
`timescale 1ns/100ps

// Clock sources that sit outside the block: two generators and the external pin
module sbrc_src_model (
	// Clock
	input wire logic mclk,
	// Generator enables and external clock
	output logic gen_a_tick,
	output logic gen_b_tick,
	output logic ext_clk_pin
);
	// Phase of generator B, one driver only
	logic b_phase = 1'b0;

	// Generator A ticks every cycle so that rate checks stay short
	assign gen_a_tick = 1'b1;
	// Generator B ticks every other cycle
	always @(posedge mclk) begin
		b_phase <= ~b_phase;
	end
	assign gen_b_tick = b_phase;
	// External clock near 32 MHz, unrelated in phase to mclk
	initial begin
		ext_clk_pin = 1'b0;
		forever #15.6 ext_clk_pin = ~ext_clk_pin;
	end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`include "sbrc_defs.svh"

// Register and sample level testbench of the buffer and rate control
module tb;
	// Small buffer so that full is reached quickly
	localparam int DEPTH = 8;
	sbrc_pkg::sbrc_req_t reg_req = '0;
	sbrc_pkg::sbrc_sample_t smp = '0;
	logic mclk = 1'b0, rst_b = 1'b0, host_sync_pulse = 1'b0, flush_on_sync = 1'b0;
	logic edge_sel_fall = 1'b0, buf_rd = 1'b0, scan_sync_sel = 1'b0;
	logic gen_a_tick, gen_b_tick, ext_clk_pin, buf_wr_en, buf_flush, thr_flag, thr_evt, empty_evt;
	logic [1:0] conv_tick, conv_mode0, conv_mode1;
	logic [31:0] reg_rdata, buf_wr_word, rd_val;
	int n_fail = 0, total_checks = 0, n_thr = 0, n_empty = 0, i, k;

	// Clock of 25 ns
	always #12.5 mclk = ~mclk;

	// Event pulses are counted, they last one cycle only
	always @(posedge mclk) begin
		if (thr_evt === 1'b1) n_thr <= n_thr + 1;
		if (empty_evt === 1'b1) n_empty <= n_empty + 1;
	end

	sbrc_src_model src (.mclk(mclk), .gen_a_tick(gen_a_tick), .gen_b_tick(gen_b_tick), .ext_clk_pin(ext_clk_pin));

	// Device with a small buffer; all loose control bits driven by the bench
	sbrc_top #(.DEPTH(DEPTH), .NCH(12)) dut (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .host_sync_pulse(host_sync_pulse), .flush_on_sync(flush_on_sync),
		.scan_sync_sel(scan_sync_sel), .edge_sel_fall(edge_sel_fall), .gen_a_tick(gen_a_tick),
		.gen_b_tick(gen_b_tick), .ext_clk_pin(ext_clk_pin), .smp(smp), .buf_rd(buf_rd),
		.buf_wr_en(buf_wr_en), .buf_wr_word(buf_wr_word), .buf_flush(buf_flush), .thr_flag(thr_flag),
		.thr_evt(thr_evt), .empty_evt(empty_evt), .conv_tick(conv_tick), .conv_mode0(conv_mode0),
		.conv_mode1(conv_mode1));

	// Compare and count
	task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Every task leaves the bench 1 ns after a rising edge
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One-cycle write strobe, then an idle cycle so strobes never merge
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		cyc(1);
		reg_req.wr = 1'b0;
		cyc(1);
	endtask

	// Read data is registered, taken one cycle after the strobe
	task rd(input logic [7:0] a);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		cyc(1);
		reg_req.rd = 1'b0;
		cyc(1);
		rd_val = reg_rdata;
	endtask

	task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(name, rd_val, exp);
	endtask

	// One sample strobe; the accept pulse is looked at in its only cycle
	task send(input logic [4:0] ch, input logic [23:0] d, input logic exp_wr, input logic [31:0] exp_w);
		smp = {1'b1, ch, d};
		cyc(1);
		smp.valid = 1'b0;
		chk("buf_wr_en", 32'(buf_wr_en), 32'(exp_wr));
		if (exp_wr) chk("buf_wr_word", buf_wr_word, exp_w);
		cyc(1);
	endtask

	task pop;
		buf_rd = 1'b1;
		cyc(1);
		buf_rd = 1'b0;
		cyc(1);
	endtask

	// Cycles between two converter ticks of group g, left in k; bounded waits
	task period(input int g);
		k = 0;
		while (conv_tick[g] !== 1'b1 && k < 1100) begin
			cyc(1);
			k++;
		end
		k = 0;
		do begin
			cyc(1);
			k++;
		end while (conv_tick[g] !== 1'b1 && k < 1100);
	endtask

	// Single place where the run ends
	task end_of_test;
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		cyc(8);
		rst_b = 1'b1;
		rchk("src_rst", `SBRC_OFS_SRC, `SBRC_RST_SRC);
		rchk("div_rst", `SBRC_OFS_DIV, `SBRC_RST_DIV);
		rchk("ctl_rst", `SBRC_OFS_CTL, `SBRC_RST_CTL);
		rchk("cnt_rst", `SBRC_OFS_CNT, 32'h0000_0000);
		rchk("unmapped", 8'h04, 32'h0000_0000);
		wr(`SBRC_OFS_SRC, 32'hFFFF_FFFF);
		rchk("src_mask", `SBRC_OFS_SRC, 32'h0000_00FF);
		// Group 1 off, group 0 on generator A
		wr(`SBRC_OFS_SRC, 32'h0000_0060);
		rchk("src", `SBRC_OFS_SRC, 32'h0000_0060);
		wr(`SBRC_OFS_DIV, 32'h0000_0100);
		rchk("div", `SBRC_OFS_DIV, 32'h0000_0100);
		wr(`SBRC_OFS_CNT, 32'h0000_0005);
		rchk("cnt_ro", `SBRC_OFS_CNT, 32'h0000_0000);
		// Acquisition starts with a flush, threshold zero
		wr(`SBRC_OFS_CTL, 32'h0008_0000);
		rchk("flush_busy", `SBRC_OFS_CTL, 32'h0008_0000);
		chk("buf_flush", 32'(buf_flush), 32'h0000_0001);
		// Poll the busy bit; each read takes two cycles
		k = 0;
		do begin
			rd(`SBRC_OFS_CTL);
			k++;
		end while (rd_val[19] !== 1'b0 && k < 300);
		chk("flush_len", 32'(k > 190 && k < 210), 32'h0000_0001);
		send(5'd2, 24'h12_3456, 1'b1, 32'h0200_3456);
		cyc(2);
		chk("flag_up", 32'(thr_flag), 32'h0000_0001);
		pop;
		cyc(2);
		chk("flag_down", 32'(thr_flag), 32'h0000_0000);
		chk("thr_evt", 32'(n_thr), 32'h0000_0001);
		chk("empty_evt", 32'(n_empty), 32'h0000_0001);
		// Falling edge selected: the rise is silent, the fall raises the event
		edge_sel_fall = 1'b1;
		send(5'd2, 24'h00_0001, 1'b1, 32'h0200_0001);
		pop;
		cyc(2);
		chk("thr_evt_fall", 32'(n_thr), 32'h0000_0002);
		chk("empty_evt_2", 32'(n_empty), 32'h0000_0002);
		edge_sel_fall = 1'b0;
		// Every width code masks the data field
		for (i = 0; i < 4; i++) begin
			wr(`SBRC_OFS_CTL, 32'(i) << 20);
			send(5'd2, 24'hFF_FFFF, 1'b1, {8'h02, 24'hFF_FFFF >> ((i == 3) ? 0 : 8 - 2 * i)});
			pop;
		end
		send(5'd7, 24'h00_0001, 1'b0, 32'h0000_0000);
		send(5'd5, 24'h00_0001, 1'b1, 32'h0500_0001);
		pop;
		wr(`SBRC_OFS_CTL, 32'h0000_0002);
		for (i = 0; i < DEPTH; i++) begin
			send(5'd0, 24'(i), 1'b1, 32'(i));
		end
		rchk("cnt_full", `SBRC_OFS_CNT, 32'(DEPTH));
		chk("flag_thr", 32'(thr_flag), 32'h0000_0001);
		send(5'd0, 24'h00_0000, 1'b0, 32'h0000_0000);
		rchk("cnt_keep", `SBRC_OFS_CNT, 32'(DEPTH));
		rchk("ovf", `SBRC_OFS_CTL, 32'h0100_0002);
		// Block intake, keep the flag by writing one
		wr(`SBRC_OFS_CTL, 32'h0104_0002);
		pop;
		send(5'd0, 24'h00_0000, 1'b0, 32'h0000_0000);
		rchk("cnt_block", `SBRC_OFS_CNT, 32'(DEPTH - 1));
		rchk("ovf_keep", `SBRC_OFS_CTL, 32'h0104_0002);
		wr(`SBRC_OFS_CTL, 32'h0000_0002);
		rchk("ovf_clr", `SBRC_OFS_CTL, 32'h0000_0002);
		flush_on_sync = 1'b1;
		host_sync_pulse = 1'b1;
		cyc(1);
		host_sync_pulse = 1'b0;
		cyc(2);
		rchk("cnt_sync", `SBRC_OFS_CNT, 32'h0000_0000);
		cyc(`SBRC_FLUSH_CYC + 10);
		pop;
		rchk("unf", `SBRC_OFS_CTL, 32'h0200_0002);
		// Code 0 halves the factor: 256 generator ticks per sample
		period(0);
		chk("rate_half", 32'(k), 32'd256);
		chk("mode0", 32'(conv_mode0), 32'h0000_0002);
		chk("mode1", 32'(conv_mode1), 32'h0000_0001);
		// Group 1 on generator B, which ticks every other cycle, divide code 1
		wr(`SBRC_OFS_SRC, 32'h0000_0010);
		period(1);
		chk("rate_gen_b", 32'(k), 32'd1024);
		// Scan sync: group 1 follows the group 0 clock and mode
		scan_sync_sel = 1'b1;
		cyc(1);
		period(1);
		chk("scan_rate", 32'(k), 32'd256);
		chk("scan_tick0", 32'(conv_tick[0]), 32'h0000_0001);
		chk("scan_mode", 32'(conv_mode1), 32'h0000_0002);
		scan_sync_sel = 1'b0;
		// Direct external clock: ticks follow the detected pin edges closely
		wr(`SBRC_OFS_SRC, 32'h0000_0015);
		period(0);
		chk("direct_ext", 32'(k <= 10), 32'h0000_0001);
		end_of_test;
	end
endmodule
